// >>> rtl/flash_host_pkg.sv
// Purpose: shared constants and carriers for the parallel nor flash host controller
// Assumes: device pins driven through flops on clk_sys (10 MHz)
// Notes: command codes and addresses are plain defaults, fixed here and not overridable in the host
package flash_host_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int BYTE_ADDR_W = 21;
  localparam int WORDS_TOTAL = 1048576;
  localparam int BYTES_TOTAL = 2097152;

  // strobe timing in ns, converted to whole cycles (least times round up)
  localparam int CLK_NS = 100;
  localparam int T_STROBE_NS = 100;
  localparam int T_ACCESS_NS = 120;
  localparam int T_RESET_NS = 500;
  localparam int N_STROBE = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int N_ACCESS = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int N_RESET = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;

  // unlock cycle addresses and data, plain defaults
  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 20'h0_0555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 20'h0_02AA;
  localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROG = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_CHIP = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_SECT = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_SUSP = 16'h00B0;
  localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_BYPASS = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_READ_RST = 16'h00F0;
  localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT1 = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT2 = 16'h0000;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;

  typedef enum logic [3:0]
  {
    OP_READ = 4'h0,
    OP_PROGRAM = 4'h1,
    OP_CHIP_ERASE = 4'h2,
    OP_SECTOR_ERASE = 4'h3,
    OP_SUSPEND = 4'h4,
    OP_RESUME = 4'h5,
    OP_BYPASS_ON = 4'h6,
    OP_BYPASS_OFF = 4'h7,
    OP_STANDBY = 4'h8,
    OP_HARD_RESET = 4'h9,
    OP_RAW_WRITE = 4'hA
  } op_t;

  typedef struct packed
  {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_t;

  typedef struct packed
  {
    logic chip_enable_n;
    logic write_strobe_n;
    logic output_gate_n;
    logic hard_restart_n;
    logic byte_mode_n;
    logic [ADDR_W-1:0] addr;
  } pins_t;

endpackage

// >>> rtl/flash_host.sv
// Purpose: host controller that drives a parallel nor flash through its strobes
// Assumes: synchronous active-low rstn; pin inputs pass two flops first
// Notes: one write or read cycle at a time; program, erase and bypass entry expand into unlock sequences
//
// Contract
// - three active-low strobes avoid bus contention
// - commands issued as plain write cycles
// - bypass mode programs with two writes
// - host may place device in standby
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter int POLL_LIMIT = 4000
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req_valid,
  input wire req_t req,
  input wire logic byte_mode,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic op_timeout,
  output logic bypass_active,
  output pins_t pins,
  output logic [DATA_W-1:0] bus_lines_out,
  output logic bus_lines_oe,
  input wire logic [DATA_W-1:0] bus_lines_in,
  input wire logic done_indicator_n
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [DATA_W-1:0] bus_meta;
  logic [DATA_W-1:0] bus_sync;
  logic ready_meta;
  logic ready_sync;

  always_ff @(posedge clk_sys)
  begin
    bus_meta <= bus_lines_in;
    bus_sync <= bus_meta;
    ready_meta <= done_indicator_n;
    ready_sync <= ready_meta;
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  typedef enum logic [3:0]
  {
    S_IDLE = 4'h0,
    S_WR_SETUP = 4'h1,
    S_WR_PULSE = 4'h2,
    S_WR_HOLD = 4'h3,
    S_RD_WAIT = 4'h4,
    S_RD_DONE = 4'h5,
    S_POLL = 4'h6,
    S_RESET = 4'h7,
    S_STANDBY = 4'h8,
    S_DONE = 4'h9
  } state_t;

  state_t state;
  state_t next_state;
  req_t cur;
  logic [2:0] step;
  logic [2:0] last_step;
  logic [CNT_W-1:0] cnt;
  logic [15:0] poll_cnt;
  logic [DATA_W-1:0] prev_status;
  logic poll_seen;

  // command expansion: each step is one write cycle
  logic [ADDR_W-1:0] step_addr;
  logic [DATA_W-1:0] step_data;
  logic [2:0] step_count;
  logic unlock_phase;
  logic is_erase;
  logic needs_poll;
  logic is_prog;

  assign is_prog = (cur.op == OP_PROGRAM);
  assign is_erase = (cur.op == OP_CHIP_ERASE) || (cur.op == OP_SECTOR_ERASE);
  assign needs_poll = is_prog || is_erase;
  // bypass programs in two writes instead of four
  assign step_count = is_prog ? (bypass_active ? 3'd2 : 3'd4) :
                      is_erase ? 3'd6 :
                      (cur.op == OP_BYPASS_ON) ? 3'd3 :
                      (cur.op == OP_BYPASS_OFF) ? 3'd2 : 3'd1;
  assign unlock_phase = (step == 3'd0) || (step == 3'd3);

  always_comb
  begin
    step_addr = unlock_phase ? UNLOCK_A1 : UNLOCK_A2;
    step_data = unlock_phase ? UNLOCK_D1 : UNLOCK_D2;
    unique case (cur.op)
      OP_PROGRAM:
      begin
        if (bypass_active)
        begin
          step_addr = (step == 3'd0) ? UNLOCK_A1 : cur.addr;
          step_data = (step == 3'd0) ? CMD_PROG : cur.data;
        end
        else if (step == 3'd2)
        begin
          step_addr = UNLOCK_A1;
          step_data = CMD_PROG;
        end
        else if (step == 3'd3)
        begin
          step_addr = cur.addr;
          step_data = cur.data;
        end
      end
      OP_CHIP_ERASE, OP_SECTOR_ERASE:
      begin
        // whole array or one sector per sequence
        if (step == 3'd2)
        begin
          step_addr = UNLOCK_A1;
          step_data = CMD_ERASE;
        end
        else if (step == 3'd5)
        begin
          step_addr = is_prog ? cur.addr : ((cur.op == OP_CHIP_ERASE) ? UNLOCK_A1 : cur.addr);
          step_data = (cur.op == OP_CHIP_ERASE) ? CMD_CHIP : CMD_SECT;
        end
      end
      OP_BYPASS_ON:
      begin
        if (step == 3'd2)
        begin
          step_addr = UNLOCK_A1;
          step_data = CMD_BYPASS;
        end
      end
      OP_BYPASS_OFF:
      begin
        step_addr = cur.addr;
        step_data = (step == 3'd0) ? CMD_BYPASS_EXIT1 : CMD_BYPASS_EXIT2;
      end
      OP_SUSPEND:
      begin
        step_addr = cur.addr;
        step_data = CMD_SUSP;
      end
      OP_RESUME:
      begin
        step_addr = cur.addr;
        step_data = CMD_RESUME;
      end
      default:
      begin
        step_addr = cur.addr;
        step_data = cur.data;
      end
    endcase
  end

  // toggle bit stops flipping once the internal routine ends
  logic toggling;
  logic cnt_done;
  logic start_op;
  logic [DATA_W-1:0] byte_masked;
  assign toggling = (bus_sync[TOGGLE_BIT] != prev_status[TOGGLE_BIT]);
  assign cnt_done = (cnt == '0);
  assign start_op = req_valid && req_ready;
  // byte mode uses only the low eight lines
  assign byte_masked = byte_mode ? {8'h00, bus_sync[7:0]} : bus_sync;
  assign last_step = step_count - 3'd1;

  always_comb
  begin
    next_state = state;
    unique case (state)
      S_IDLE:
        if (start_op)
          next_state = (req.op == OP_READ) ? S_RD_WAIT :
                       (req.op == OP_STANDBY) ? S_STANDBY :
                       (req.op == OP_HARD_RESET) ? S_RESET : S_WR_SETUP;
      S_WR_SETUP: next_state = S_WR_PULSE;
      S_WR_PULSE: if (cnt_done) next_state = S_WR_HOLD;
      S_WR_HOLD:
        if (step != last_step) next_state = S_WR_SETUP;
        else next_state = needs_poll ? S_RD_WAIT : S_DONE;
      S_RD_WAIT: if (cnt_done) next_state = (cur.op == OP_READ) ? S_RD_DONE : S_POLL;
      S_RD_DONE: next_state = S_DONE;
      S_POLL:
        if (poll_seen && !toggling && ready_sync) next_state = S_DONE;
        else if (poll_cnt == 16'(POLL_LIMIT)) next_state = S_DONE;
      S_RESET: if (cnt_done) next_state = S_DONE;
      S_STANDBY: if (req_valid) next_state = S_IDLE;
      S_DONE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state <= S_IDLE;
      cur <= '0;
      step <= 3'd0;
      cnt <= '0;
      poll_cnt <= 16'h0000;
      prev_status <= 16'h0000;
      poll_seen <= 1'b0;
      bypass_active <= 1'b0;
      op_timeout <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (start_op)
      begin
        cur <= req;
        step <= 3'd0;
        op_timeout <= 1'b0;
        cnt <= (req.op == OP_HARD_RESET) ? CNT_W'(N_RESET) : CNT_W'(N_ACCESS);
      end
      else if (state == S_WR_SETUP)
        cnt <= CNT_W'(N_STROBE - 1);
      else if (state == S_WR_HOLD)
      begin
        step <= step + 3'd1;
        cnt <= CNT_W'(N_ACCESS);
      end
      else if (!cnt_done)
        cnt <= cnt - CNT_W'(1);
      if (state == S_POLL)
      begin
        prev_status <= bus_sync;
        poll_seen <= 1'b1;
        poll_cnt <= poll_cnt + 16'h0001;
        if (poll_cnt == 16'(POLL_LIMIT))
          op_timeout <= 1'b1;
      end
      else
      begin
        poll_seen <= 1'b0;
        poll_cnt <= 16'h0000;
      end
      if (state == S_WR_HOLD && step == last_step)
      begin
        if (cur.op == OP_BYPASS_ON)
          bypass_active <= 1'b1;
        if (cur.op == OP_BYPASS_OFF)
          bypass_active <= 1'b0;
      end
      // hard restart also leaves bypass mode
      if (state == S_RESET)
        bypass_active <= 1'b0;
    end
  end

  // ****************************************************************
  // pin drivers, all from flops
  // ****************************************************************
  logic next_ce_n;
  logic next_we_n;
  logic next_oe_n;
  logic next_drive;
  // strobes kept exclusive so the data lines never fight
  assign next_ce_n = !(state inside {S_WR_SETUP, S_WR_PULSE, S_WR_HOLD, S_RD_WAIT, S_POLL});
  assign next_we_n = (state != S_WR_PULSE);
  assign next_oe_n = !(state inside {S_RD_WAIT, S_POLL});
  assign next_drive = state inside {S_WR_SETUP, S_WR_PULSE, S_WR_HOLD};

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pins <= '{chip_enable_n: 1'b1, write_strobe_n: 1'b1, output_gate_n: 1'b1,
                hard_restart_n: 1'b0, byte_mode_n: 1'b1, addr: '0};
      bus_lines_out <= 16'h0000;
      bus_lines_oe <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end
    else
    begin
      pins.chip_enable_n <= next_ce_n;
      pins.write_strobe_n <= next_we_n;
      pins.output_gate_n <= next_oe_n;
      pins.hard_restart_n <= (next_state != S_RESET);
      pins.byte_mode_n <= !byte_mode;
      // address held steady between cycles lets the device sleep
      if (next_state inside {S_WR_SETUP, S_WR_PULSE, S_WR_HOLD})
        pins.addr <= step_addr;
      else if (start_op)
        pins.addr <= req.addr;
      bus_lines_out <= step_data;
      bus_lines_oe <= next_drive && (next_state != S_WR_HOLD || state == S_WR_PULSE);
      req_ready <= (next_state == S_IDLE);
      rsp_valid <= (state == S_DONE);
      if (state == S_RD_DONE || state == S_POLL)
        rsp_data <= byte_masked;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_NO_CONTENTION:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      bus_lines_oe |-> pins.output_gate_n)
    else $error("host drives bus while output gate active");

  AST_WE_OE_EXCL:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !(!pins.write_strobe_n && !pins.output_gate_n))
    else $error("write and output strobes active together");

  AST_WE_NEEDS_CE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !pins.write_strobe_n |-> !pins.chip_enable_n && bus_lines_oe)
    else $error("write strobe without chip enable or data");

  AST_BYPASS_SET:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == S_WR_HOLD && step == last_step && cur.op == OP_BYPASS_ON) |=> bypass_active)
    else $error("bypass mode not entered");

  AST_RESET_PULSE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == S_IDLE && start_op && req.op == OP_HARD_RESET) |=> ##1 !pins.hard_restart_n)
    else $error("hard restart not driven");

  AST_POLL_BOUND:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == S_POLL && poll_cnt == 16'(POLL_LIMIT)) |=> state == S_DONE && op_timeout)
    else $error("poll limit not honoured");

  AST_STANDBY_CE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == S_STANDBY) [*2] |-> pins.chip_enable_n)
    else $error("chip enable active in standby");

  AST_RSP_AFTER_DONE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == S_DONE) |=> rsp_valid && state == S_IDLE)
    else $error("no response after completion");

endmodule

// >>> verification/flash_dev_model.sv
// Purpose: behavioural parallel nor flash facing the host controller
// Assumes: strobes and address come from host flops; no pull on the data lines
// Notes: busy time shortened, sector 0 erase runs eight times longer; top sector protected
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int BUSY_NS = 1500,
  parameter logic [4:0] PROT_SECT = 5'h1F
)
(
  input wire pins_t pins,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic done_indicator_n
);
  // ****************************************
  // storage and read path
  // ****************************************
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] prev = '0;
  logic [DATA_W-1:0] dout = 16'hFFFF;
  logic busy = 1'b0;
  logic bp = 1'b0;
  logic tog = 1'b0;
  int st = 0;
  time end_t = 0;
  time left = 0;
  logic susp = 1'b0;
  logic low_supply = 1'b0;
  wire drv = !pins.chip_enable_n && !pins.output_gate_n && pins.write_strobe_n;
  wire [19:0] a = pins.addr;
  wire prot = (a[19:15] == PROT_SECT);
  // released lines flip every half cycle so a stale value never passes for data
  assign dq_out = !drv ? ~prev : (pins.byte_mode_n ? dout : {~prev[15:8], dout[7:0]});
  assign done_indicator_n = ~busy;
  always #50 prev <= dq_out;
  always #50 if (busy && $time >= end_t) busy = 1'b0;
  always @(negedge pins.output_gate_n)
  begin
    if (busy)
    begin
      tog <= ~tog;
      dout <= {9'h000, ~tog, 6'h00};
    end
    else
      dout <= mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
  end
  // ****************************************
  // command decoding on the write strobe
  // ****************************************
  always @(posedge pins.write_strobe_n)
  begin
    if (!pins.chip_enable_n && pins.hard_restart_n && !busy && !low_supply)
    begin
      if (st == 3 || st == 6)
      begin
        if (st == 3 && !prot)
          mem[a] = mem.exists(a) ? (mem[a] & dq_in) : dq_in;
        // chip erase still spares a protected sector
        if (st == 6 && (dq_in == CMD_CHIP || (dq_in == CMD_SECT && !prot)))
          foreach (mem[k])
            if (k[19:15] != PROT_SECT && (dq_in == CMD_CHIP || k[19:15] == a[19:15]))
              mem[k] = 16'hFFFF;
        busy = 1'b1;
        // a long sector 0 erase lets the bench reach the poll limit and suspend
        end_t = $time + ((st == 6 && dq_in == CMD_SECT && a[19:15] == 5'h00) ? 8 * BUSY_NS : BUSY_NS);
        st = 0;
      end
      else if (susp && st == 0 && dq_in == CMD_RESUME)
      begin
        busy = 1'b1;
        end_t = $time + left;
        susp = 1'b0;
      end
      else if (bp && st == 0 && dq_in == CMD_PROG) st = 3;
      else if (bp && st == 0 && dq_in == CMD_BYPASS_EXIT1) st = 7;
      else if (st == 7)
      begin
        bp = (dq_in != CMD_BYPASS_EXIT2);
        st = 0;
      end
      else if (st == 0 || st == 4) st = (a == UNLOCK_A1 && dq_in == UNLOCK_D1) ? st + 1 : 0;
      else if (st == 1 || st == 5) st = (a == UNLOCK_A2 && dq_in == UNLOCK_D2) ? st + 1 : 0;
      else if (st == 2)
      begin
        bp = bp || (dq_in == CMD_BYPASS);
        st = (dq_in == CMD_PROG) ? 3 : ((dq_in == CMD_ERASE) ? 4 : 0);
      end
    end
  end
  // suspend is the one command taken while busy; it parks the remaining time
  always @(posedge pins.write_strobe_n)
  begin
    if (!pins.chip_enable_n && pins.hard_restart_n && busy && dq_in == CMD_SUSP)
    begin
      left = end_t - $time;
      busy = 1'b0;
      susp = 1'b1;
    end
  end
  always @(negedge pins.hard_restart_n)
  begin
    st = 0;
    susp = 1'b0;
    bp = 1'b0;
    busy = 1'b0;
  end
endmodule

// >>> verification/flash_host_tb_top.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: device model with shortened busy time; POLL_LIMIT lowered to 50
// Notes: one task per scenario; verdict printed once by report_and_stop
`timescale 1ns/1ps
module flash_host_tb_top
  import flash_host_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  req_t req = '0;
  logic byte_mode = 1'b0;
  logic req_ready, rsp_valid, op_timeout, bypass_active, bus_lines_oe, done_indicator_n;
  logic [DATA_W-1:0] rsp_data, bus_lines_out, dev_q, got;
  pins_t pins;
  int miscompares = 0;
  int check_count = 0;
  int wr_cnt = 0;
  int rst_cnt = 0;
  int cycles = 0;
  wire [DATA_W-1:0] dq = bus_lines_oe ? bus_lines_out : dev_q;

  flash_host #(.POLL_LIMIT(50)) uut (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
    .req(req), .byte_mode(byte_mode), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .op_timeout(op_timeout), .bypass_active(bypass_active), .pins(pins),
    .bus_lines_out(bus_lines_out), .bus_lines_oe(bus_lines_oe), .bus_lines_in(dq),
    .done_indicator_n(done_indicator_n));
  flash_dev_model dev (.pins(pins), .dq_in(dq), .dq_out(dev_q),
    .done_indicator_n(done_indicator_n));

  initial forever #50 clk_sys = ~clk_sys;
  // ****************************************
  // monitors and shared tasks
  // ****************************************
  always @(negedge pins.write_strobe_n) wr_cnt++;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (rstn && !pins.hard_restart_n) rst_cnt++;
    if (rstn && !pins.output_gate_n && (!pins.write_strobe_n || bus_lines_oe))
    begin
      $display("[FAIL] bus_contention expected 0 seen 1");
      miscompares++;
    end
    if (cycles == 60000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  task automatic do_op(input op_t op, input logic [19:0] a, input logic [15:0] d);
    int n;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = '{op, a, d};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (req_ready !== 1'b1 && n < 200);
    @(negedge clk_sys);
    req_valid = 1'b0;
    if (op == OP_STANDBY) return;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    got = rsp_data;
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_program;
    wr_cnt = 0;
    do_op(OP_RAW_WRITE, 20'h0_0000, CMD_READ_RST);
    chk("raw_writes", 16'h0001, wr_cnt[15:0]);
    wr_cnt = 0;
    do_op(OP_PROGRAM, 20'h4_0010, 16'h1234);
    chk("prog_writes", 16'h0004, wr_cnt[15:0]);
    chk("ready_pin", 16'h0001, {15'h0000, done_indicator_n});
    chk("timeout", 16'h0000, {15'h0000, op_timeout});
    do_op(OP_READ, 20'h4_0010, 16'h0000);
    chk("prog_read", 16'h1234, got);
  endtask
  task automatic t_erase;
    do_op(OP_PROGRAM, 20'h4_8000, 16'h00AA);
    do_op(OP_SECTOR_ERASE, 20'h4_0000, 16'h0000);
    do_op(OP_READ, 20'h4_0010, 16'h0000);
    chk("erased", 16'hFFFF, got);
    do_op(OP_READ, 20'h4_8000, 16'h0000);
    chk("other_sector", 16'h00AA, got);
  endtask
  task automatic t_bypass;
    do_op(OP_BYPASS_ON, 20'h0_0000, 16'h0000);
    chk("bypass_on", 16'h0001, {15'h0000, bypass_active});
    wr_cnt = 0;
    do_op(OP_PROGRAM, 20'h5_0000, 16'h5AC3);
    chk("bypass_writes", 16'h0002, wr_cnt[15:0]);
    do_op(OP_BYPASS_OFF, 20'h0_0000, 16'h0000);
    chk("bypass_off", 16'h0000, {15'h0000, bypass_active});
    do_op(OP_READ, 20'h5_0000, 16'h0000);
    chk("bypass_read", 16'h5AC3, got);
  endtask
  task automatic t_byte_protect;
    @(negedge clk_sys);
    byte_mode = 1'b1;
    do_op(OP_READ, 20'h5_0000, 16'h0000);
    chk("byte_read", 16'h00C3, got);
    @(negedge clk_sys);
    byte_mode = 1'b0;
    dev.low_supply = 1'b1;
    do_op(OP_PROGRAM, 20'h5_0000, 16'h0000);
    dev.low_supply = 1'b0;
    do_op(OP_READ, 20'h5_0000, 16'h0000);
    chk("low_supply", 16'h5AC3, got);
    do_op(OP_PROGRAM, 20'hF_8000, 16'h0000);
    do_op(OP_READ, 20'hF_8000, 16'h0000);
    chk("protected", 16'hFFFF, got);
  endtask
  task automatic t_standby_reset;
    do_op(OP_STANDBY, 20'h0_0000, 16'h0000);
    repeat (5) @(negedge clk_sys);
    chk("standby_ce", 16'h0001, {15'h0000, pins.chip_enable_n});
    chk("sleep_addr", 16'h0000, pins.addr[15:0]);
    do_op(OP_READ, 20'h5_0000, 16'h0000);
    chk("wake_read", 16'h5AC3, got);
    rst_cnt = 0;
    do_op(OP_HARD_RESET, 20'h0_0000, 16'h0000);
    // the pulse spans the loaded count plus the edge that leaves the reset state
    chk("reset_pulse", 16'(N_RESET + 1), rst_cnt[15:0]);
    do_op(OP_READ, 20'h4_8000, 16'h0000);
    chk("read_after_reset", 16'h00AA, got);
    do_op(OP_CHIP_ERASE, 20'h0_0000, 16'h0000);
    do_op(OP_READ, 20'h5_0000, 16'h0000);
    chk("chip_erased", 16'hFFFF, got);
  endtask
  task automatic t_suspend;
    do_op(OP_PROGRAM, 20'h0_0100, 16'h0F0F);
    do_op(OP_SECTOR_ERASE, 20'h0_0000, 16'h0000);
    chk("erase_timeout", 16'h0001, {15'h0000, op_timeout});
    do_op(OP_SUSPEND, 20'h0_0000, 16'h0000);
    chk("timeout_clear", 16'h0000, {15'h0000, op_timeout});
    chk("suspend_ready", 16'h0001, {15'h0000, done_indicator_n});
    do_op(OP_READ, 20'h4_8000, 16'h0000);
    chk("suspend_read", 16'h00AA, got);
    do_op(OP_RESUME, 20'h0_0000, 16'h0000);
    chk("resume_busy", 16'h0000, {15'h0000, done_indicator_n});
    wait (done_indicator_n === 1'b1);
    do_op(OP_READ, 20'h0_0100, 16'h0000);
    chk("resumed_erase", 16'hFFFF, got);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_program();
    t_erase();
    t_bypass();
    t_byte_protect();
    t_suspend();
    t_standby_reset();
    report_and_stop();
  end
endmodule
